/* File: dv/jbsa_jtag_ctl.sv */
// Behavioural model of the external controller that clocks the test port.
`timescale 1ns/100ps
module jbsa_jtag_ctl (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo_line
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // Inputs change while the clock is low; the answer is taken just before the rise.
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #80;
      q = tdo_line;
      tck = 1'b1;
      #80;
      tck = 1'b0;
   endtask
   task automatic to_idle();
      logic q;
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
   // Scan from idle back to idle; the clock stands low between scans and the
   // data line shows the inverse of the last bit once its value is spent.
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
      output logic [31:0] dout);
      logic q;
      dout = '0;
      #3.7;
      step(1'b1, 1'b0, q);
      if (ir) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, ~din[n-1], q);
      step(1'b0, ~din[n-1], q);
   endtask
endmodule

/* File: dv/jbsa_tap_port_sva.sv */
// Port-level assertions for the test access port block.
`timescale 1ns/100ps
module jbsa_sva (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic tck,
   input wire logic tdo,
   input wire logic tdo_oe_n,
   input wire logic [jbsa_pkg::PIN_N-1:0] core_out,
   input wire logic [jbsa_pkg::PIN_N-1:0] pin_out,
   input wire logic extest_on,
   input wire logic cfg_busy,
   input wire logic [jbsa_pkg::CFG_W-1:0] cfg_data,
   input wire logic cfg_valid,
   input wire logic cfg_ready,
   input wire logic cfg_jtag_sel
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_reset_quiet: assert property ($rose(resetn) |-> tdo_oe_n && !extest_on && !cfg_valid)
      else $error("Outputs active right after reset release");
   a_pins_follow: assert property ((!extest_on ##1 !extest_on) |-> pin_out == $past(core_out))
      else $error("Pins do not follow the core outside extest");
   // Leaving extest, for example when configuration starts, hands the pins back to the core.
   a_extest_hold: assert property ((extest_on && !tck) [*8]
      |=> !extest_on || $stable(pin_out))
      else $error("Pins moved under extest without a scan step");
   a_busy_gate: assert property (cfg_busy [*3] |-> !extest_on)
      else $error("Extest active while configuration is busy");
   a_tdo_on_fall: assert property (($changed(tdo) || $changed(tdo_oe_n))
      |-> !tck && !$past(tck) && !$past(tck, 2))
      else $error("Data out changed away from a test clock fall");
   a_cfg_hold: assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data))
      else $error("Configuration byte lost while stalled");
   a_valid_drop: assert property ($fell(cfg_valid) |-> $past(cfg_ready))
      else $error("Configuration valid fell without a take");
   a_push_source: assert property ($rose(cfg_valid) |-> $past(cfg_jtag_sel, 2))
      else $error("Configuration byte without the load instruction");
endmodule

bind jbsa_tap_port jbsa_sva i_sva (.clk_sys(clk_sys), .resetn(resetn), .tck(tck), .tdo(tdo),
   .tdo_oe_n(tdo_oe_n), .core_out(core_out), .pin_out(pin_out), .extest_on(extest_on),
   .cfg_busy(cfg_busy), .cfg_data(cfg_data), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
   .cfg_jtag_sel(cfg_jtag_sel));

/* File: dv/test_jtag_boundary_scan_access.sv */
// Self-checking bench for the test access port block.
`timescale 1ns/100ps
module test_jtag_boundary_scan_access;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic tck, tms, tdi, tdo, tdo_oe_n, tdo_r, tdo_oe_n_r, sel_red, tdo_line;
   logic [7:0] pin_in, core_out, pin_out, pin_out_r, cfg_data;
   logic extest_on, extest_on_r, cfg_busy, cfg_valid, cfg_ready, cfg_jtag_sel;
   logic [31:0] user_word, res, d;
   logic [15:0] probe, snap, pre;
   logic [7:0] bytes [5];
   int err_total = 0;
   int tests_run = 0;
   always #5 clk_sys = ~clk_sys;
   // The data-out line has a pull-up, so a released line reads one.
   assign tdo_line = sel_red ? (tdo_oe_n_r ? 1'b1 : tdo_r) : (tdo_oe_n ? 1'b1 : tdo);
   jbsa_tap_port i_dut (.clk_sys(clk_sys), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out),
      .extest_on(extest_on), .cfg_busy(cfg_busy), .user_identification_word(user_word),
      .probe(probe), .cfg_data(cfg_data), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
      .cfg_jtag_sel(cfg_jtag_sel));
   jbsa_tap_port #(.REDUCED(1'b1)) i_dut_red (.clk_sys(clk_sys), .resetn(resetn), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo_r), .tdo_oe_n(tdo_oe_n_r), .pin_in(pin_in),
      .core_out(core_out), .pin_out(pin_out_r), .extest_on(extest_on_r), .cfg_busy(cfg_busy),
      .user_identification_word(user_word), .probe(probe), .cfg_data(), .cfg_valid(),
      .cfg_ready(cfg_ready), .cfg_jtag_sel());
   jbsa_jtag_ctl i_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_line(tdo_line));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic ir(input logic [9:0] op);
      i_ctl.scan(1'b1, 10, {22'h0, op}, res);
      tick(4);
   endtask
   task automatic dr(input int n, input logic [31:0] v);
      i_ctl.scan(1'b0, n, v, res);
      tick(4);
   endtask
   // A single stage that captures zero delays the stream by one bit.
   function automatic logic [31:0] byp(input logic [31:0] v, input int n);
      return (v << 1) & ((32'h1 << n) - 1);
   endfunction
   // Takes bytes with a consumer that stalls at random; ready is set just after an edge
   // and the take is checked just before the next edge, so it matches what the design sees.
   task automatic drain(input int n);
      int k;
      k = 0;
      for (int t = 0; t < 4000 && k < n; t++) begin
         cfg_ready = 1'($urandom);
         #8;
         if (cfg_valid === 1'b1 && cfg_ready) begin
            chk("cfg byte", bytes[k], cfg_data);
            k++;
         end
         tick(1);
      end
      if (k < n) begin
         err_total++;
         end_of_test();
      end
   endtask
   initial begin
      repeat (100000) @(posedge clk_sys);
      err_total++;
      end_of_test();
   end
   initial begin
      {pin_in, core_out, cfg_busy, cfg_ready, sel_red, user_word, probe} = '0;
      void'($urandom(76));
      tick(16);
      resetn = 1'b1;
      tick(2);
      i_ctl.to_idle();
      chk("oe idle", 1, tdo_oe_n);
      dr(32, $urandom);
      chk("id after reset", jbsa_pkg::IDCODE_DEF, res);
      ir(jbsa_pkg::OP_IDCODE_DEF);
      chk("ir capture", 32'h001, res);
      dr(32, $urandom);
      chk("id word", jbsa_pkg::IDCODE_DEF, res);
      user_word = $urandom;
      ir(jbsa_pkg::OP_USER_WORD_DEF);
      dr(32, $urandom);
      chk("user word", user_word, res);
      ir(jbsa_pkg::OP_BYPASS_DEF);
      for (int i = 0; i < 3; i++) begin
         d = (i == 0) ? 32'hff : $urandom;
         dr(8, d);
         chk("bypass", byp(d, 8), res);
      end
      {pin_in, core_out, probe, pre} = {8'($urandom), 8'($urandom), 16'($urandom), 16'($urandom)};
      snap = probe;
      ir(jbsa_pkg::OP_SAMPLE_DEF);
      dr(16, {16'h0, pre});
      chk("sample pins", pin_in, res[7:0]);
      chk("pins undisturbed", core_out, pin_out);
      ir(jbsa_pkg::OP_EXTEST_DEF);
      chk("extest on", 1, extest_on);
      core_out = 8'($urandom);
      tick(3);
      chk("preload driven", pre[15:8], pin_out);
      {pin_in, pre, probe} = {8'($urandom), 16'($urandom), 16'($urandom)};
      dr(16, {16'h0, pre});
      chk("extest capture", pin_in, res[7:0]);
      chk("extest update", pre[15:8], pin_out);
      sel_red = 1'b1;
      d = $urandom;
      dr(8, d);
      chk("reduced bypass", byp(d, 8), res);
      chk("reduced no extest", 0, extest_on_r);
      chk("reduced pins", core_out, pin_out_r);
      sel_red = 1'b0;
      cfg_busy = 1'b1;
      tick(4);
      chk("busy blocks extest", 0, extest_on);
      d = $urandom;
      dr(8, d);
      chk("busy bypass", byp(d, 8), res);
      ir(jbsa_pkg::OP_CFG_LOAD_DEF);
      chk("cfg select", 1, cfg_jtag_sel);
      for (int i = 0; i < 4; i++) begin
         bytes[i] = (i == 0) ? 8'h00 : 8'($urandom);
         dr(8, {24'h0, bytes[i]});
      end
      chk("fifo head", {1'b1, bytes[0]}, {cfg_valid, cfg_data});
      bytes[4] = 8'hff;
      fork
         dr(8, {24'h0, bytes[4]});
         drain(5);
      join
      cfg_busy = 1'b0;
      ir(jbsa_pkg::OP_MONITOR_DEF);
      dr(32, $urandom);
      chk("monitor live", probe, res[31:16]);
      chk("monitor snapshot", snap, res[15:0]);
      sel_red = 1'b1;
      dr(32, $urandom);
      chk("reduced monitor", probe, res[31:16]);
      sel_red = 1'b0;
      resetn = 1'b0;
      tick(3);
      resetn = 1'b1;
      tick(2);
      i_ctl.to_idle();
      dr(32, $urandom);
      chk("id after second reset", jbsa_pkg::IDCODE_DEF, res);
      // The reduced option has no identification word, so reset leaves it in bypass.
      sel_red = 1'b1;
      d = $urandom;
      dr(8, d);
      chk("reduced reset bypass", byp(d, 8), res);
      end_of_test();
   end
endmodule

/* File: shared/jbsa_pkg.sv */
// Shared constants and types for the test access port block.
package jbsa_pkg;
   localparam int IR_LEN = 10;
   localparam logic [IR_LEN-1:0] OP_EXTEST_DEF = 10'h000;
   localparam logic [IR_LEN-1:0] OP_SAMPLE_DEF = 10'h005;
   localparam logic [IR_LEN-1:0] OP_BYPASS_DEF = 10'h3ff;
   localparam logic [IR_LEN-1:0] OP_USER_WORD_DEF = 10'h007;
   localparam logic [IR_LEN-1:0] OP_IDCODE_DEF = 10'h006;
   localparam logic [IR_LEN-1:0] OP_CFG_LOAD_DEF = 10'h002;
   localparam logic [IR_LEN-1:0] OP_MONITOR_DEF = 10'h00e;
   localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;
   // Identification value is arbitrary; bit 0 is one as the standard demands.
   localparam logic [31:0] IDCODE_DEF = 32'h0a5c_3001;
   localparam int PIN_N = 8;
   localparam int BSR_LEN = 16;
   localparam int PROBE_W = 16;
   localparam int DR_W = 32;
   localparam int ID_LEN = 32;
   localparam int USR_LEN = 32;
   localparam int CFG_W = 8;
   localparam int MON_LEN = 32;
   localparam int FIFO_DEPTH = 4;
   typedef enum logic [3:0] {
      TS_RESET = 4'h0,
      TS_IDLE = 4'h1,
      TS_SEL_DR = 4'h3,
      TS_CAP_DR = 4'h2,
      TS_SH_DR = 4'h6,
      TS_EX1_DR = 4'h7,
      TS_PAU_DR = 4'h5,
      TS_EX2_DR = 4'h4,
      TS_UPD_DR = 4'hc,
      TS_SEL_IR = 4'hd,
      TS_CAP_IR = 4'hf,
      TS_SH_IR = 4'he,
      TS_EX1_IR = 4'ha,
      TS_PAU_IR = 4'hb,
      TS_EX2_IR = 4'h9,
      TS_UPD_IR = 4'h8
   } jbsa_tap_e;
   typedef enum logic [2:0] {
      DS_BYPASS = 3'h0,
      DS_BSR = 3'h1,
      DS_ID = 3'h2,
      DS_USR = 3'h3,
      DS_CFG = 3'h4,
      DS_MON = 3'h5
   } jbsa_dsel_e;
endpackage

/* File: shared/jbsa_stream_if.sv */
// Valid/ready stream carrier between the port logic and its FIFO.
`timescale 1ns/100ps
interface jbsa_stream_if #(
   parameter int W = 8
);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

/* File: verilog/jbsa_fifo.sv */
// Shift-register FIFO whose head entry is a flip-flop.
`timescale 1ns/100ps
module jbsa_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input wire logic clk_sys,
   input wire logic resetn,
   jbsa_stream_if.snk wr,
   jbsa_stream_if.src rd
);
   logic [W-1:0] mem_q [D];
   logic [W-1:0] mem_d [D];
   logic [D-1:0] vld_q;
   logic [D-1:0] vld_d;
   logic placed;

   // Ready ignores a same-cycle pop so that it stays a plain flop output.
   assign wr.ready = ~vld_q[D-1];
   assign rd.valid = vld_q[0];
   assign rd.data = mem_q[0];

   always_comb begin
      mem_d = mem_q;
      vld_d = vld_q;
      placed = 1'b0;
      if (vld_q[0] && rd.ready) begin
         for (int i = 0; i < D - 1; i++) begin
            mem_d[i] = mem_q[i + 1];
            vld_d[i] = vld_q[i + 1];
         end
         vld_d[D-1] = 1'b0;
      end
      if (wr.valid && !vld_q[D-1]) begin
         for (int i = 0; i < D; i++) begin
            if (!placed && !vld_d[i]) begin
               mem_d[i] = wr.data;
               vld_d[i] = 1'b1;
               placed = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         vld_q <= '0;
         for (int i = 0; i < D; i++) begin
            mem_q[i] <= '0;
         end
      end else begin
         vld_q <= vld_d;
         mem_q <= mem_d;
      end
   end
endmodule

/* File: verilog/jbsa_tap_port.sv */
// Test access port with boundary scan, identification, configuration and monitor scans.
// Functional notes
// - Sixteen-state TAP controller; instruction and data shift from TDI to TDO.
// - Boundary-scan instructions fall back to bypass while configuration is busy.
// - Configuration bytes arrive through the test port and leave through a FIFO.
// - Sample/preload captures pins without disturbing them and preloads output cells.
// - Extest drives preloaded cells onto pins and captures the input pins.
// - Bypass places a single stage between TDI and TDO.
// - User word instruction shifts out the 32-bit user identification word.
// - Identification instruction shifts out the device identification word.
// - The controller issues the configuration-load instruction to configure the device.
// - Monitor instruction scans internal probes sampled at system clock speed.
// - Sample/preload also snapshots the internal probes for the monitor.
// - Reduced option keeps only the bypass and monitor instructions.
`timescale 1ns/100ps
module jbsa_tap_port #(
   parameter bit REDUCED = 1'b0,
   parameter logic [jbsa_pkg::IR_LEN-1:0] OP_EXTEST = jbsa_pkg::OP_EXTEST_DEF,
   parameter logic [jbsa_pkg::IR_LEN-1:0] OP_SAMPLE = jbsa_pkg::OP_SAMPLE_DEF,
   parameter logic [jbsa_pkg::IR_LEN-1:0] OP_BYPASS = jbsa_pkg::OP_BYPASS_DEF,
   parameter logic [jbsa_pkg::IR_LEN-1:0] OP_USER_WORD = jbsa_pkg::OP_USER_WORD_DEF,
   parameter logic [jbsa_pkg::IR_LEN-1:0] OP_IDCODE = jbsa_pkg::OP_IDCODE_DEF,
   parameter logic [jbsa_pkg::IR_LEN-1:0] OP_CFG_LOAD = jbsa_pkg::OP_CFG_LOAD_DEF,
   parameter logic [jbsa_pkg::IR_LEN-1:0] OP_MONITOR = jbsa_pkg::OP_MONITOR_DEF,
   parameter logic [31:0] IDCODE_VAL = jbsa_pkg::IDCODE_DEF
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe_n,
   input wire logic [jbsa_pkg::PIN_N-1:0] pin_in,
   input wire logic [jbsa_pkg::PIN_N-1:0] core_out,
   output logic [jbsa_pkg::PIN_N-1:0] pin_out,
   output logic extest_on,
   input wire logic cfg_busy,
   input wire logic [jbsa_pkg::USR_LEN-1:0] user_identification_word,
   input wire logic [jbsa_pkg::PROBE_W-1:0] probe,
   output logic [jbsa_pkg::CFG_W-1:0] cfg_data,
   output logic cfg_valid,
   input wire logic cfg_ready,
   output logic cfg_jtag_sel
);
   localparam int IRL = jbsa_pkg::IR_LEN;
   localparam int DRW = jbsa_pkg::DR_W;
   localparam int PN = jbsa_pkg::PIN_N;
   localparam int BSR_PAD = jbsa_pkg::DR_W - jbsa_pkg::BSR_LEN;

   // Pin synchronisers: {tdi, tms, tck} and the input pins.
   logic [2:0] jsync_a_q;
   logic [2:0] jsync_b_q;
   logic [PN-1:0] psync_a_q;
   logic [PN-1:0] psync_b_q;
   logic tck_prev_q;
   logic tck_rise;
   logic tck_fall;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         jsync_a_q <= 3'h0;
         jsync_b_q <= 3'h0;
         psync_a_q <= '0;
         psync_b_q <= '0;
         tck_prev_q <= 1'b0;
      end else begin
         jsync_a_q <= {tdi, tms, tck};
         jsync_b_q <= jsync_a_q;
         psync_a_q <= pin_in;
         psync_b_q <= psync_a_q;
         tck_prev_q <= jsync_b_q[0];
      end
   end

   assign tck_rise = jsync_b_q[0] & ~tck_prev_q;
   assign tck_fall = ~jsync_b_q[0] & tck_prev_q;

   // Port state.
   jbsa_pkg::jbsa_tap_e tap_q, tap_d;
   logic [IRL-1:0] ir_q, ir_d;
   logic [IRL-1:0] irs_q, irs_d;
   logic [DRW-1:0] dr_q, dr_d;
   logic [jbsa_pkg::BSR_LEN-1:0] bsr_upd_q, bsr_upd_d;
   logic [jbsa_pkg::PROBE_W-1:0] mon_q, mon_d;
   logic [jbsa_pkg::CFG_W-1:0] pbyte_q, pbyte_d;
   logic push_q, push_d;
   logic pend_q, pend_d;
   logic tms_h_q, tms_h_d;
   logic tdi_h_q, tdi_h_d;
   logic tdo_q, tdo_d;
   logic tdo_oe_n_q, tdo_oe_n_d;
   logic [PN-1:0] pin_out_q, pin_out_d;
   logic extest_q, extest_d;
   logic cfg_sel_q, cfg_sel_d;
   logic scan_ok;
   jbsa_pkg::jbsa_dsel_e dsel;

   jbsa_stream_if #(.W(jbsa_pkg::CFG_W)) fill_if ();
   jbsa_stream_if #(.W(jbsa_pkg::CFG_W)) drain_if ();

   assign fill_if.data = pbyte_q;
   assign fill_if.valid = push_q;
   assign drain_if.ready = cfg_ready;
   assign cfg_data = drain_if.data;
   assign cfg_valid = drain_if.valid;

   jbsa_fifo #(
      .W(jbsa_pkg::CFG_W),
      .D(jbsa_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .wr(fill_if.snk),
      .rd(drain_if.src)
   );

   function automatic int dr_len(input jbsa_pkg::jbsa_dsel_e s);
      unique case (s)
         jbsa_pkg::DS_BYPASS: dr_len = 1;
         jbsa_pkg::DS_BSR: dr_len = jbsa_pkg::BSR_LEN;
         jbsa_pkg::DS_ID: dr_len = jbsa_pkg::ID_LEN;
         jbsa_pkg::DS_USR: dr_len = jbsa_pkg::USR_LEN;
         jbsa_pkg::DS_CFG: dr_len = jbsa_pkg::CFG_W;
         jbsa_pkg::DS_MON: dr_len = jbsa_pkg::MON_LEN;
         default: dr_len = 1;
      endcase
   endfunction

   function automatic jbsa_pkg::jbsa_tap_e tap_next(
      input jbsa_pkg::jbsa_tap_e s,
      input logic m
   );
      unique case (s)
         jbsa_pkg::TS_RESET: tap_next = m ? jbsa_pkg::TS_RESET : jbsa_pkg::TS_IDLE;
         jbsa_pkg::TS_IDLE: tap_next = m ? jbsa_pkg::TS_SEL_DR : jbsa_pkg::TS_IDLE;
         jbsa_pkg::TS_SEL_DR: tap_next = m ? jbsa_pkg::TS_SEL_IR : jbsa_pkg::TS_CAP_DR;
         jbsa_pkg::TS_CAP_DR: tap_next = m ? jbsa_pkg::TS_EX1_DR : jbsa_pkg::TS_SH_DR;
         jbsa_pkg::TS_SH_DR: tap_next = m ? jbsa_pkg::TS_EX1_DR : jbsa_pkg::TS_SH_DR;
         jbsa_pkg::TS_EX1_DR: tap_next = m ? jbsa_pkg::TS_UPD_DR : jbsa_pkg::TS_PAU_DR;
         jbsa_pkg::TS_PAU_DR: tap_next = m ? jbsa_pkg::TS_EX2_DR : jbsa_pkg::TS_PAU_DR;
         jbsa_pkg::TS_EX2_DR: tap_next = m ? jbsa_pkg::TS_UPD_DR : jbsa_pkg::TS_SH_DR;
         jbsa_pkg::TS_UPD_DR: tap_next = m ? jbsa_pkg::TS_SEL_DR : jbsa_pkg::TS_IDLE;
         jbsa_pkg::TS_SEL_IR: tap_next = m ? jbsa_pkg::TS_RESET : jbsa_pkg::TS_CAP_IR;
         jbsa_pkg::TS_CAP_IR: tap_next = m ? jbsa_pkg::TS_EX1_IR : jbsa_pkg::TS_SH_IR;
         jbsa_pkg::TS_SH_IR: tap_next = m ? jbsa_pkg::TS_EX1_IR : jbsa_pkg::TS_SH_IR;
         jbsa_pkg::TS_EX1_IR: tap_next = m ? jbsa_pkg::TS_UPD_IR : jbsa_pkg::TS_PAU_IR;
         jbsa_pkg::TS_PAU_IR: tap_next = m ? jbsa_pkg::TS_EX2_IR : jbsa_pkg::TS_PAU_IR;
         jbsa_pkg::TS_EX2_IR: tap_next = m ? jbsa_pkg::TS_UPD_IR : jbsa_pkg::TS_SH_IR;
         jbsa_pkg::TS_UPD_IR: tap_next = m ? jbsa_pkg::TS_SEL_DR : jbsa_pkg::TS_IDLE;
      endcase
   endfunction

   // Instruction decode; unknown opcodes fall back to the bypass stage.
   always_comb begin
      scan_ok = !REDUCED && !cfg_busy;
      dsel = jbsa_pkg::DS_BYPASS;
      if (ir_q == OP_MONITOR) begin
         dsel = jbsa_pkg::DS_MON;
      end else if (!REDUCED) begin
         if (ir_q == OP_IDCODE) begin
            dsel = jbsa_pkg::DS_ID;
         end else if (ir_q == OP_USER_WORD) begin
            dsel = jbsa_pkg::DS_USR;
         end else if (ir_q == OP_CFG_LOAD) begin
            dsel = jbsa_pkg::DS_CFG;
         end else if ((ir_q == OP_SAMPLE || ir_q == OP_EXTEST) && scan_ok) begin
            dsel = jbsa_pkg::DS_BSR;
         end
      end
   end

   always_comb begin
      int len;
      len = dr_len(dsel);
      tap_d = tap_q;
      ir_d = ir_q;
      irs_d = irs_q;
      dr_d = dr_q;
      bsr_upd_d = bsr_upd_q;
      mon_d = mon_q;
      pbyte_d = pbyte_q;
      push_d = push_q;
      pend_d = pend_q;
      tms_h_d = tms_h_q;
      tdi_h_d = tdi_h_q;
      tdo_d = tdo_q;
      tdo_oe_n_d = tdo_oe_n_q;
      if (fill_if.ready) begin
         push_d = 1'b0;
      end
      // A held configuration byte stalls the controller until the FIFO takes it.
      if (pend_q && !push_q) begin
         pend_d = 1'b0;
         tap_d = tap_next(tap_q, tms_h_q);
         case (tap_q)
            jbsa_pkg::TS_RESET: begin
               ir_d = OP_IDCODE;
            end
            jbsa_pkg::TS_CAP_IR: begin
               irs_d = jbsa_pkg::IR_CAPTURE;
            end
            jbsa_pkg::TS_SH_IR: begin
               irs_d = {tdi_h_q, irs_q[IRL-1:1]};
            end
            jbsa_pkg::TS_UPD_IR: begin
               ir_d = irs_q;
            end
            jbsa_pkg::TS_CAP_DR: begin
               dr_d = '0;
               case (dsel)
                  jbsa_pkg::DS_BSR: begin
                     dr_d = {{BSR_PAD{1'b0}}, pin_out_q, psync_b_q};
                     if (ir_q == OP_SAMPLE) begin
                        mon_d = probe;
                     end
                  end
                  jbsa_pkg::DS_ID: begin
                     dr_d = IDCODE_VAL;
                  end
                  jbsa_pkg::DS_USR: begin
                     dr_d = user_identification_word;
                  end
                  jbsa_pkg::DS_CFG: begin
                     dr_d[0] = cfg_busy;
                  end
                  jbsa_pkg::DS_MON: begin
                     dr_d = {probe, mon_q};
                  end
                  default: begin
                  end
               endcase
            end
            jbsa_pkg::TS_SH_DR: begin
               for (int i = 0; i < DRW; i++) begin
                  if (i == len - 1) begin
                     dr_d[i] = tdi_h_q;
                  end else if (i < len - 1) begin
                     dr_d[i] = dr_q[i + 1];
                  end else begin
                     dr_d[i] = 1'b0;
                  end
               end
            end
            jbsa_pkg::TS_UPD_DR: begin
               if (dsel == jbsa_pkg::DS_BSR) begin
                  bsr_upd_d = dr_q[jbsa_pkg::BSR_LEN-1:0];
               end
               if (dsel == jbsa_pkg::DS_CFG) begin
                  push_d = 1'b1;
                  pbyte_d = dr_q[jbsa_pkg::CFG_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end
      if (tck_rise) begin
         pend_d = 1'b1;
         tms_h_d = jsync_b_q[1];
         tdi_h_d = jsync_b_q[2];
      end
      // TDO changes only on the falling edge, so the far end samples it stable.
      if (tck_fall) begin
         tdo_d = (tap_q == jbsa_pkg::TS_SH_IR) ? irs_q[0] : dr_q[0];
         tdo_oe_n_d = !(tap_q == jbsa_pkg::TS_SH_IR || tap_q == jbsa_pkg::TS_SH_DR);
      end
      extest_d = (dsel == jbsa_pkg::DS_BSR) && (ir_q == OP_EXTEST);
      pin_out_d = extest_d ? bsr_upd_q[jbsa_pkg::BSR_LEN-1:PN] : core_out;
      cfg_sel_d = (dsel == jbsa_pkg::DS_CFG);
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tap_q <= jbsa_pkg::TS_RESET;
         ir_q <= OP_IDCODE;
         irs_q <= '0;
         dr_q <= '0;
         bsr_upd_q <= '0;
         mon_q <= '0;
         pbyte_q <= '0;
         push_q <= 1'b0;
         pend_q <= 1'b0;
         tms_h_q <= 1'b1;
         tdi_h_q <= 1'b0;
         tdo_q <= 1'b0;
         tdo_oe_n_q <= 1'b1;
         pin_out_q <= '0;
         extest_q <= 1'b0;
         cfg_sel_q <= 1'b0;
      end else begin
         tap_q <= tap_d;
         ir_q <= ir_d;
         irs_q <= irs_d;
         dr_q <= dr_d;
         bsr_upd_q <= bsr_upd_d;
         mon_q <= mon_d;
         pbyte_q <= pbyte_d;
         push_q <= push_d;
         pend_q <= pend_d;
         tms_h_q <= tms_h_d;
         tdi_h_q <= tdi_h_d;
         tdo_q <= tdo_d;
         tdo_oe_n_q <= tdo_oe_n_d;
         pin_out_q <= pin_out_d;
         extest_q <= extest_d;
         cfg_sel_q <= cfg_sel_d;
      end
   end

   assign tdo = tdo_q;
   assign tdo_oe_n = tdo_oe_n_q;
   assign pin_out = pin_out_q;
   assign extest_on = extest_q;
   assign cfg_jtag_sel = cfg_sel_q;
endmodule
